// *** common/cmp_blank_pkg.sv ***
package cmp_blank_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] MASK_OFF = 4'h0;
  localparam logic [3:0] FLTR_OFF = 4'h4;
  localparam logic [3:0] REF1_OFF = 4'h8;
  localparam logic [3:0] REF2_OFF = 4'hc;
  // Writable bit masks; all other bits read as zero
  localparam logic [15:0] MASK_WMASK = 16'hbfff;
  localparam logic [15:0] FLTR_WMASK = 16'h007f;
  localparam logic [15:0] REF_WMASK  = 16'h0cff;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  // Mask register field positions
  localparam int MLS_BIT  = 15;
  localparam int AND_OUTPUT_INV_ENABLE_BIT = 7;
  localparam int AND_OUTPUT_ENABLE_BIT = 6;
  localparam int AND_IN_B_ENABLE_BIT = 3;
  localparam int AND_IN_B_INV_ENABLE_BIT = 2;
  localparam int AND_IN_A_ENABLE_BIT = 1;
  localparam int AND_IN_A_INV_ENABLE_BIT = 0;
  // Filter register field positions
  localparam int FSEL_LSB = 4;
  localparam int FEN_BIT  = 3;
  localparam int FDIV_LSB = 0;
  // Reference register field positions
  localparam int RNG_HI_BIT = 11;
  localparam int RSEL_BIT   = 10;
  localparam int RPWR_BIT   = 7;
  localparam int ROE_BIT    = 6;
  localparam int RNG_LO_BIT = 5;
  localparam int RSS_BIT    = 4;
  localparam int RVAL_LSB   = 0;
  // Filter depth in agreeing samples
  localparam int FILT_SAMPLES = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** design/comparator_blank_filter_ref_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - B enable bit feeds mask input B into the AND gate.
// - B inverted enable bit feeds inverted mask input B into the AND gate.
// - A enable bit feeds mask input A into the AND gate.
// - A inverted enable bit feeds inverted mask input A into the AND gate.
// - Filter clock select picks timers, PWM syncs, oscillator or peripheral clock.
// - Filter clock divided by two to the power of the divide code.
// - Unimplemented bits ignore writes and read zero.
// - Reference one select bit picks external positive reference or ladder.
// - Reference two select bit picks reference two or one for inverting input.
// - Enable bit powers each reference generator.
// - Output enable bit connects reference level to its pin.
// - Range field is bit 11 upper, bit 5 lower.
// - Source bit selects external reference or analog supply ladder span.
// - Four-bit value picks ladder tap.
// - Level select chooses blocking of high or low comparator signals.
// - AND output reaches OR gate only via its enable bits.
module comparator_blank_filter_ref_ctrl
  import cmp_blank_pkg::*;
#(
  parameter int SAMPLES = FILT_SAMPLES
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Comparator side, one-cycle tick inputs for clock sources
  input  wire logic        compRaw,
  input  wire logic        mask_input_a,
  input  wire logic        mask_input_b,
  input  wire logic        orInputPart,
  input  wire logic        peripheral_clock,
  input  wire logic        oscTick,
  input  wire logic        pwm_sync_out_one,
  input  wire logic        pwm_sync_out_two,
  input  wire logic        timer2_clock,
  input  wire logic        timer3_clock,
  input  wire logic        timer4_clock,
  input  wire logic        timer5_clock,
  output logic             compOut,
  output logic             maskActive,
  // Analog controls, two references
  output logic [1:0]       ref_power_enable,
  output logic [1:0]       ref_pin_output_enable,
  output logic [3:0]       ref_range_select,
  output logic [1:0]       ref_source_select,
  output logic [7:0]       ref_value_select,
  output logic             ladder_reference_input,
  output logic             invInputFromRefTwo
);
  // Elaboration guard: one sample is no filter, and the agreement counter is kept small
  if (SAMPLES < 2 || SAMPLES > 8) begin
    $error("SAMPLES out of range");
  end

  logic [15:0] maskReg_q, fltrReg_q, ref1Reg_q, ref2Reg_q;
  logic [3:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awHave_q, wHave_q;
  logic        doWrite;

  // Write path: address and data taken in any order, response after both
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_q <= 1'b0;
      end
    end
  end

  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHave_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte-lane merge of a write into a 16-bit register under its mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb, input logic [15:0] wm);
    logic [15:0] be;
    be = {{8{strb[1]}}, {8{strb[0]}}} & wm;
    return (old & ~be) | (dat[15:0] & be);
  endfunction

  // Register file, reset clears all fields
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      maskReg_q <= REG_RESET;
      fltrReg_q <= REG_RESET;
      ref1Reg_q <= REG_RESET;
      ref2Reg_q <= REG_RESET;
    end else if (doWrite && awAddr_q[1:0] == 2'b00) begin
      case (awAddr_q)
        MASK_OFF: maskReg_q <= merge(maskReg_q, wData_q, wStrb_q, MASK_WMASK);
        FLTR_OFF: fltrReg_q <= merge(fltrReg_q, wData_q, wStrb_q, FLTR_WMASK);
        REF1_OFF: ref1Reg_q <= merge(ref1Reg_q, wData_q, wStrb_q, REF_WMASK);
        REF2_OFF: ref2Reg_q <= merge(ref2Reg_q, wData_q, wStrb_q, REF_WMASK);
        default: ;
      endcase
    end
  end

  // Read path, single read in flight; unaligned gets SLVERR
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          MASK_OFF: s_axi_rdata <= {16'h0000, maskReg_q};
          FLTR_OFF: s_axi_rdata <= {16'h0000, fltrReg_q};
          REF1_OFF: s_axi_rdata <= {16'h0000, ref1Reg_q};
          REF2_OFF: s_axi_rdata <= {16'h0000, ref2Reg_q};
          default:  s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Filter source selection
  logic [2:0] fSel;
  logic       srcTick, sampleEn;
  assign fSel = fltrReg_q[FSEL_LSB +: 3];
  always_comb begin
    case (fSel)
      3'h7:    srcTick = timer5_clock;
      3'h6:    srcTick = timer4_clock;
      3'h5:    srcTick = timer3_clock;
      3'h4:    srcTick = timer2_clock;
      3'h3:    srcTick = pwm_sync_out_two;
      3'h2:    srcTick = pwm_sync_out_one;
      3'h1:    srcTick = oscTick;
      default: srcTick = peripheral_clock;
    endcase
  end

  sample_divider #(.MAX_CODE(7)) u_div (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .srcTick  (srcTick),
    .divCode  (fltrReg_q[FDIV_LSB +: 3]),
    .sampleEn (sampleEn)
  );

  // Debounce: output follows only after SAMPLES agreeing samples
  logic [3:0] agree_q;
  logic       filtered_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      agree_q    <= '0;
      filtered_q <= 1'b0;
    end else if (sampleEn) begin
      if (compRaw == filtered_q) begin
        agree_q <= '0;
      end else if (agree_q == 4'(SAMPLES - 1)) begin
        filtered_q <= compRaw;
        agree_q    <= '0;
      end else begin
        agree_q <= agree_q + 1'b1;
      end
    end
  end

  // Blanking: AND gate over enabled inputs, unused inputs ignored
  logic andIn, andOut, orOut, pre;
  always_comb begin
    andIn = maskReg_q[AND_IN_B_ENABLE_BIT] | maskReg_q[AND_IN_B_INV_ENABLE_BIT] | maskReg_q[AND_IN_A_ENABLE_BIT] | maskReg_q[AND_IN_A_INV_ENABLE_BIT];
    andOut = andIn
           & (!maskReg_q[AND_IN_B_ENABLE_BIT]  | mask_input_b)
           & (!maskReg_q[AND_IN_B_INV_ENABLE_BIT] | !mask_input_b)
           & (!maskReg_q[AND_IN_A_ENABLE_BIT]  | mask_input_a)
           & (!maskReg_q[AND_IN_A_INV_ENABLE_BIT] | !mask_input_a);
    orOut = orInputPart
          | (maskReg_q[AND_OUTPUT_ENABLE_BIT] & andOut)
          | (maskReg_q[AND_OUTPUT_INV_ENABLE_BIT] & !andOut);
    pre = fltrReg_q[FEN_BIT] ? filtered_q : compRaw;
  end

  // Registered outputs; blanking holds the inactive level for the selected polarity
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      compOut    <= 1'b0;
      maskActive <= 1'b0;
    end else begin
      maskActive <= orOut;
      if (orOut) begin
        compOut <= maskReg_q[MLS_BIT] ? 1'b1 : 1'b0;
      end else begin
        compOut <= pre;
      end
    end
  end

  // Analog reference controls registered from the two reference words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ref_power_enable       <= '0;
      ref_pin_output_enable  <= '0;
      ref_range_select       <= '0;
      ref_source_select      <= '0;
      ref_value_select       <= '0;
      ladder_reference_input <= 1'b0;
      invInputFromRefTwo     <= 1'b0;
    end else begin
      ref_power_enable      <= {ref2Reg_q[RPWR_BIT], ref1Reg_q[RPWR_BIT]};
      ref_pin_output_enable <= {ref2Reg_q[ROE_BIT], ref1Reg_q[ROE_BIT]};
      ref_range_select      <= {ref2Reg_q[RNG_HI_BIT], ref2Reg_q[RNG_LO_BIT],
                                ref1Reg_q[RNG_HI_BIT], ref1Reg_q[RNG_LO_BIT]};
      ref_source_select     <= {ref2Reg_q[RSS_BIT], ref1Reg_q[RSS_BIT]};
      ref_value_select      <= {ref2Reg_q[RVAL_LSB +: 4], ref1Reg_q[RVAL_LSB +: 4]};
      ladder_reference_input <= ref1Reg_q[RSEL_BIT];
      invInputFromRefTwo     <= ref2Reg_q[RSEL_BIT];
    end
  end

  // Checks: reference controls follow their register bits one cycle later, and unimplemented filter and reference bits stay zero
  ref_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ref_power_enable[0] == $past(ref1Reg_q[RPWR_BIT]))
    else $error("ref power mismatch");
  ref_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ladder_reference_input == $past(ref1Reg_q[RSEL_BIT]))
    else $error("ref select mismatch");
  inv_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 invInputFromRefTwo == $past(ref2Reg_q[RSEL_BIT]))
    else $error("inverting select mismatch");
  ref_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ref_pin_output_enable == $past({ref2Reg_q[ROE_BIT], ref1Reg_q[ROE_BIT]}))
    else $error("pin enable mismatch");
  range_bits_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ref_range_select[1:0] == $past({ref1Reg_q[RNG_HI_BIT], ref1Reg_q[RNG_LO_BIT]}))
    else $error("range assembly wrong");
  ref_source_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ref_source_select == $past({ref2Reg_q[RSS_BIT], ref1Reg_q[RSS_BIT]}))
    else $error("source select mismatch");
  ref_value_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ref_value_select == $past({ref2Reg_q[RVAL_LSB +: 4], ref1Reg_q[RVAL_LSB +: 4]}))
    else $error("value select mismatch");
  fltr_unimpl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fltrReg_q[15:7] == '0) && ({ref1Reg_q[15:12], ref1Reg_q[9:8], ref2Reg_q[15:12], ref2Reg_q[9:8]} == '0))
    else $error("unimplemented bit set");

  // Output path: bypass, blanking level and the route of the gate into the final mask
  bypass_path_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!fltrReg_q[FEN_BIT] && !orOut) |=> compOut == $past(compRaw))
    else $error("bypass mismatch");
  blank_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    orOut |=> compOut == $past(maskReg_q[MLS_BIT]))
    else $error("blank level wrong");
  mask_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!maskReg_q[AND_OUTPUT_ENABLE_BIT] && !maskReg_q[AND_OUTPUT_INV_ENABLE_BIT] && !orInputPart) |=> !maskActive)
    else $error("gate output leaked into mask");

  // AND gate: any enabled input at its blocking level forces the gate low
  and_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (maskReg_q[AND_IN_B_ENABLE_BIT] && !mask_input_b) |-> !andOut)
    else $error("and input b ignored");
  and_b_inv_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (maskReg_q[AND_IN_B_INV_ENABLE_BIT] && mask_input_b) |-> !andOut)
    else $error("and inverted b ignored");
  and_a_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (maskReg_q[AND_IN_A_ENABLE_BIT] && !mask_input_a) |-> !andOut)
    else $error("and input a ignored");
  and_a_inv_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (maskReg_q[AND_IN_A_INV_ENABLE_BIT] && mask_input_a) |-> !andOut)
    else $error("and inverted a ignored");

  // Filter steps: a first disagreeing sample starts the count, the last one turns the output
  sequence firstDisagree;
    sampleEn && (compRaw != filtered_q) && (agree_q == 4'h0);
  endsequence
  sequence lastAgree;
    sampleEn && (compRaw != filtered_q) && (agree_q == 4'(SAMPLES - 1));
  endsequence
  filt_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!sampleEn) |=> $stable(filtered_q))
    else $error("filter moved off sample");
  agree_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    firstDisagree |=> (agree_q == 4'h1) && $stable(filtered_q))
    else $error("filter count did not start");
  filt_flip_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    lastAgree |=> $changed(filtered_q))
    else $error("filter did not turn");
endmodule

// *** design/sample_divider.sv ***
`timescale 1ns/1ps
// Counts source edges and pulses every 2**divCode of them
module sample_divider #(
  parameter int MAX_CODE = 7
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       srcTick,
  input  wire logic [2:0] divCode,
  output logic            sampleEn
);
  // Elaboration guard: the counter cannot hold a terminal count wider than seven bits
  if (MAX_CODE < 1 || MAX_CODE > 7) begin
    $error("MAX_CODE out of range");
  end

  logic [MAX_CODE-1:0] cnt_q;
  logic [MAX_CODE-1:0] limit;

  // Terminal count is 2**code - 1
  assign limit = MAX_CODE'((1 << divCode) - 1);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (srcTick) begin
      cnt_q <= (cnt_q >= limit) ? '0 : cnt_q + 1'b1;
    end
  end

  assign sampleEn = srcTick && (cnt_q >= limit);
endmodule

// *** dv/comparator_blank_filter_ref_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module comparator_blank_filter_ref_ctrl_tb_top;
  import cmp_blank_pkg::*;
  localparam int SAMP = 3;
  logic        sys_clk, resetn;
  logic [3:0]  awAddr, arAddr, wStrb;
  logic [31:0] wData, rData;
  logic        awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [1:0]  bResp, rResp, refPwr, refOe, refSrc;
  logic        compRaw, maskA, maskB, orPart, compOut, maskActive, refInSel, invRefTwo;
  logic [7:0]  tick, refVal;
  logic [3:0]  refRng;
  logic [1:0]  resp;
  logic [31:0] rd;
  int          errTotal, testsRun;

  comparator_blank_filter_ref_ctrl #(.SAMPLES(SAMP)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .compRaw(compRaw), .mask_input_a(maskA), .mask_input_b(maskB), .orInputPart(orPart),
    .peripheral_clock(tick[0]), .oscTick(tick[1]), .pwm_sync_out_one(tick[2]), .pwm_sync_out_two(tick[3]),
    .timer2_clock(tick[4]), .timer3_clock(tick[5]), .timer4_clock(tick[6]), .timer5_clock(tick[7]),
    .compOut(compOut), .maskActive(maskActive), .ref_power_enable(refPwr), .ref_pin_output_enable(refOe),
    .ref_range_select(refRng), .ref_source_select(refSrc), .ref_value_select(refVal),
    .ladder_reference_input(refInSel), .invInputFromRefTwo(invRefTwo));

  // Free-running system clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic endOfTest();
    if (errTotal == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Address and data offered together; each dropped when taken, bready held until the answer
  task automatic axiWrite(input logic [3:0] addr, input logic [15:0] data, output logic [1:0] rsp);
    @(posedge sys_clk);
    awAddr <= addr; awValid <= 1'b1; wData <= {16'h0000, data}; wStrb <= 4'hf; wValid <= 1'b1; bReady <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    rsp = bResp;
    bReady <= 1'b0;
  endtask

  task automatic axiRead(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] rsp);
    @(posedge sys_clk);
    arAddr <= addr; arValid <= 1'b1; rReady <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    data = rData;
    rsp = rResp;
    rReady <= 1'b0;
  endtask

  // Write then give the register two edges to reach the outputs
  task automatic wr(input logic [3:0] addr, input logic [15:0] data);
    axiWrite(addr, data, resp);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Reset values, write masks of every register and the unaligned refusal
  task automatic regScenario();
    logic [3:0]  offs [4] = '{MASK_OFF, FLTR_OFF, REF1_OFF, REF2_OFF};
    logic [15:0] msk  [4] = '{MASK_WMASK, FLTR_WMASK, REF_WMASK, REF_WMASK};
    check("outputs after reset", {refPwr, refOe, refSrc, refRng, refVal, refInSel, invRefTwo}, 32'h0);
    axiWrite(4'h1, 16'hffff, resp);
    check("unaligned bresp", resp, RESP_SLVERR);
    axiRead(4'h1, rd, resp);
    check("unaligned rdata", rd, 32'h0);
    check("unaligned rresp", resp, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      axiRead(offs[i], rd, resp);
      check("reset value", rd, {16'h0000, REG_RESET});
      axiWrite(offs[i], 16'hffff, resp);
      check("write bresp", resp, RESP_OKAY);
      axiRead(offs[i], rd, resp);
      check("readback", rd, {16'h0000, msk[i]});
      wr(offs[i], 16'h0000);
    end
  endtask

  // Reference fields reach their analog controls; all four range codes per register
  task automatic refScenario();
    for (int r = 0; r < 4; r++) begin
      wr(REF1_OFF, 16'((r >> 1) << RNG_HI_BIT) | 16'((r & 1) << RNG_LO_BIT));
      wr(REF2_OFF, 16'((r & 1) << RNG_HI_BIT) | 16'((r >> 1) << RNG_LO_BIT));
      check("range select", refRng, {28'h0, 2'(((r & 1) << 1) | (r >> 1)), 2'(r)});
    end
    wr(REF1_OFF, 16'h0cba);
    wr(REF2_OFF, 16'h0455);
    check("input select one", refInSel, 32'h1);
    check("inverting select", invRefTwo, 32'h1);
    check("power enables", refPwr, 32'h1);
    check("pin enables", refOe, 32'h2);
    check("range codes", refRng, 32'h3);
    check("source select", refSrc, 32'h3);
    check("value select", refVal, 32'h5a);
  endtask

  // Every AND input selection, both inputs, every AND output routing
  task automatic andScenario();
    logic a, b, andV;
    for (int o = 0; o < 4; o++)
      for (int e = 0; e < 16; e++) begin
        wr(MASK_OFF, 16'((o << AND_OUTPUT_ENABLE_BIT) | e));
        for (int ab = 0; ab < 4; ab++) begin
          a = ab[0];
          b = ab[1];
          @(posedge sys_clk);
          maskA <= a;
          maskB <= b;
          waitCyc(3);
          andV = (e != 0) && (!e[3] || b) && (!e[2] || !b) && (!e[1] || a) && (!e[0] || !a);
          check("mask output", maskActive, {31'h0, (o[0] & andV) | (o[1] & ~andV)});
        end
      end
  endtask

  // Blanking level and bypass with the filter off
  task automatic blankScenario();
    logic [15:0] cfg [4] = '{16'h8042, 16'h0042, 16'h0042, 16'h0042};
    logic        raw [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic        ina [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(MASK_OFF, cfg[i]);
      @(posedge sys_clk);
      compRaw <= raw[i];
      maskA <= ina[i];
      maskB <= 1'b0;
      waitCyc(3);
      check("blanked output", compOut, ina[i] ? {31'h0, cfg[i][MLS_BIT]} : {31'h0, raw[i]});
    end
    // The outside OR term alone must raise the mask and blank at the low level
    @(posedge sys_clk);
    orPart <= 1'b1;
    waitCyc(3);
    check("or term mask", {maskActive, compOut}, 32'h2);
    @(posedge sys_clk);
    orPart <= 1'b0;
    waitCyc(3);
  endtask

  task automatic pulse(input logic [7:0] which, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick <= which;
      @(posedge sys_clk);
      tick <= 8'h00;
    end
    waitCyc(3);
  endtask

  // Each clock source with its own divide code; output moves only after SAMP divided samples
  task automatic filterScenario();
    int n;
    logic lvl;
    for (int s = 0; s < 8; s++) begin
      n = 1 << s;
      lvl = s[0];
      wr(FLTR_OFF, 16'((s << FSEL_LSB) | (1 << FEN_BIT) | s));
      @(posedge sys_clk);
      compRaw <= lvl;
      pulse(8'(1 << s), SAMP * n);
      check("filter settled", compOut, {31'h0, lvl});
      @(posedge sys_clk);
      compRaw <= ~lvl;
      pulse(~8'(1 << s), SAMP * n);
      check("other sources", compOut, {31'h0, lvl});
      pulse(8'(1 << s), (SAMP - 1) * n);
      check("too few samples", compOut, {31'h0, lvl});
      pulse(8'(1 << s), n);
      check("filter moved", compOut, {31'h0, ~lvl});
    end
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    endOfTest();
  end

  initial begin
    errTotal = 0;
    testsRun = 0;
    resetn = 1'b0;
    {awAddr, arAddr, wStrb, wData} = '0;
    {awValid, wValid, bReady, arValid, rReady, compRaw, maskA, maskB, orPart} = '0;
    tick = 8'h00;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    waitCyc(2);
    regScenario();
    refScenario();
    andScenario();
    blankScenario();
    filterScenario();
    endOfTest();
  end
endmodule
